// ### rtl/timer_pkg.sv
package timer_pkg;
  localparam int         NCH      = 5;
  localparam int         PHASE_CH = 2;
  localparam int         PAIR_LO  = 3;
  localparam int         DMA_NCH  = 4;
  // per-channel block: channel index in addr[6:4], offset in addr[3:0]
  localparam logic [3:0] OFS_CTRL  = 4'h0;
  localparam logic [3:0] OFS_FLAGS = 4'h2;
  localparam logic [3:0] OFS_EN    = 4'h3;
  localparam logic [3:0] OFS_CNT   = 4'h4;
  localparam logic [3:0] OFS_GRA   = 4'h6;
  localparam logic [3:0] OFS_GRB   = 4'h8;
  localparam logic [3:0] OFS_BRA   = 4'hA;
  localparam logic [3:0] OFS_BRB   = 4'hC;
  localparam logic [6:0] ADR_START = 7'h50;
  localparam logic [6:0] ADR_SYNC  = 7'h51;
  localparam logic [6:0] ADR_MODE  = 7'h52;
  localparam logic [6:0] ADR_FUNC  = 7'h53;
  localparam logic [7:0] FLAGS_RST = 8'hF8;
  localparam logic [7:0] EN_RST    = 8'hF8;
  localparam logic [7:0] RO_MASK   = 8'hF8;
  localparam int         WRAP_BIT  = 2;
  localparam int         EVB_BIT   = 1;
  localparam int         EVA_BIT   = 0;
  localparam int         CLR_LSB   = 0;
  localparam int         CAP_A_BIT = 4;
  localparam int         CAP_B_BIT = 5;
  localparam int         BOTH_BIT  = 6;
  localparam int         PHASE_BIT = 6;
  localparam logic [1:0] CLR_A     = 2'h1;
  localparam logic [1:0] CLR_B     = 2'h2;
  localparam logic [1:0] CLR_SYNC  = 2'h3;
  localparam logic [1:0] CMB_COMP  = 2'h2;
  localparam logic [1:0] CMB_RSYNC = 2'h3;
  localparam logic [15:0] CNT_MAX  = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage : timer_pkg

// ### rtl/timer_channel_status_irq.sv
// What this block does
// - per-channel event flags register, resets to F8 on reset and standby
// - per-channel interrupt enable register, resets to F8, all enables off
// - upper five bits of both registers read one, writes ignored
// - wrap flag sets on counter FFFF to 0000 and on 0000 to FFFF
// - downward wrap only in channel 2 phase counting or 3/4 complementary
// - flag clears by reading it as one then writing zero; one never sets
// - event B flag sets on compare match with B or capture into B
// - event A flag sets on compare match with A or capture into A
// - channels 0 to 3: DMA start by event A request clears event A flag
// - each flag requests an interrupt only when its enable bit is set
// - enable bit 2 gates the wrap interrupt request
// - enable bit 1 gates the event B interrupt request
// - enable bit 0 gates the event A interrupt request
// - counter, general and buffer registers are 16-bit, word or byte access
// - other registers are 8-bit; word access reaches both bytes of the pair in one transfer
// - counters count up except channel 2 phase counting and 3/4 complementary; general registers act as capture or compare
// - write to a grouped counter loads every grouped counter together
// - grouped counters with synchronous clear select clear together
// - PWM: pin A high at compare A, low at compare B, both compare
// - reset-sync PWM: channels 3/4 drive six pins, counter 4 uncompared
// - complementary PWM: channels 3/4 count up/down, six complementary pins
// - phase counting: channel 2 counts up/down from two clock inputs
// - after upward wrap the counter keeps counting from zero
// - compare event fires as the counter leaves the matching value
`timescale 1ns/100ps
`default_nettype none
module timer_channel_status_irq
  import timer_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        standby_i,
  input  wire logic [6:0]  bus_addr_i,
  input  wire logic        bus_rd_i,
  input  wire logic        bus_wr_i,
  input  wire logic        bus_word_i,
  input  wire logic [15:0] bus_wdata_i,
  output logic      [15:0] bus_rdata_o,
  input  wire logic [4:0]  capture_compare_pin_a_i,
  input  wire logic [4:0]  capture_compare_pin_b_i,
  output logic      [4:0]  capture_compare_pin_a_o,
  output logic      [4:0]  capture_compare_pin_a_oe_o,
  output logic      [4:0]  capture_compare_pin_b_o,
  output logic      [4:0]  capture_compare_pin_b_oe_o,
  output logic             inverted_out_pin_a_o,
  output logic             inverted_out_pin_b_o,
  input  wire logic        ext_clock_in_a_i,
  input  wire logic        ext_clock_in_b_i,
  input  wire logic [3:0]  dma_ack_a_i,
  output logic      [4:0]  wrap_irq_request_o,
  output logic      [4:0]  event_a_irq_request_o,
  output logic      [4:0]  event_b_irq_request_o
);

  logic [2:0]  flg_q  [NCH];
  logic [2:0]  en_q   [NCH];
  logic [2:0]  arm_q  [NCH];
  logic [7:0]  ctrl_q [NCH];
  logic [15:0] cnt_q  [NCH];
  logic [15:0] gra_q  [NCH];
  logic [15:0] grb_q  [NCH];
  logic [15:0] bra_q  [NCH];
  logic [15:0] brb_q  [NCH];
  logic [4:0]  start_q, sync_q, dir_q, pa_q, pb_q, outa_q, outb_q;
  logic [7:0]  mode_q, func_q;
  logic        qa_q, qb_q;
  logic [2:0]  ph_q;
  logic [15:0] rdata_q;

  logic [4:0]  tick, down, cmpa, cmpb, seta, setb, wrap, clro, clr, wcnt, load;
  logic [2:0]  fclr [NCH];
  logic [2:0]  wch;
  logic [15:0] wval;
  logic        any_w, any_c, qstep, qup, pairm, compm, rsyncm;

  function automatic logic hit(input logic [6:0] t);
    hit = (bus_addr_i == t) | (bus_word_i & (bus_addr_i[6:1] == t[6:1]));
  endfunction : hit

  // word access: even byte on [15:8], odd byte on [7:0]; byte access on [7:0]
  function automatic logic [7:0] bdat(input logic [6:0] t);
    bdat = (bus_word_i & ~t[0]) ? bus_wdata_i[15:8] : bus_wdata_i[7:0];
  endfunction : bdat

  function automatic logic [15:0] wr16(input logic [15:0] o, input logic [6:0] t);
    wr16 = {hit(t) ? bdat(t) : o[15:8], hit(t | 7'h01) ? bdat(t | 7'h01) : o[7:0]};
  endfunction : wr16

  function automatic logic [6:0] adr(input int c, input logic [3:0] o);
    adr = {c[2:0], o};
  endfunction : adr

  function automatic logic [7:0] rbyte(input logic [6:0] t);
    logic [2:0] c;
    logic [15:0] w;
    c = t[6:4];
    w = 16'h0000;
    rbyte = 8'h00;
    if (t == ADR_START) rbyte = {3'h0, start_q};
    else if (t == ADR_SYNC) rbyte = {3'h0, sync_q};
    else if (t == ADR_MODE) rbyte = mode_q;
    else if (t == ADR_FUNC) rbyte = func_q;
    else if (c < 3'(NCH)) begin
      case ({t[3:1], 1'b0})
        OFS_CNT: w = cnt_q[c];
        OFS_GRA: w = gra_q[c];
        OFS_GRB: w = grb_q[c];
        OFS_BRA: w = bra_q[c];
        OFS_BRB: w = brb_q[c];
        default: w = 16'h0000;
      endcase
      case (t[3:0])
        OFS_CTRL:  rbyte = ctrl_q[c];
        OFS_FLAGS: rbyte = RO_MASK | {5'h00, flg_q[c]};
        OFS_EN:    rbyte = RO_MASK | {5'h00, en_q[c]};
        default:   rbyte = t[0] ? w[7:0] : w[15:8];
      endcase
    end
  endfunction : rbyte

  // channel events and counter control
  always_comb begin
    pairm  = func_q[1];
    compm  = func_q[1:0] == CMB_COMP;
    rsyncm = func_q[1:0] == CMB_RSYNC;
    qstep  = (ext_clock_in_a_i ^ qa_q) | (ext_clock_in_b_i ^ qb_q);
    qup    = ext_clock_in_a_i ^ qb_q;
    wch    = bus_addr_i[6:4];
    wval   = (wch < 3'(NCH)) ? wr16(cnt_q[wch], {wch, OFS_CNT}) : CNT_ZERO;
    any_w  = 1'b0;
    any_c  = 1'b0;
    for (int c = 0; c < NCH; c++) begin
      if (c == PHASE_CH && mode_q[PHASE_BIT]) begin
        tick[c] = start_q[c] & qstep;
        down[c] = ~qup;
      end else begin
        tick[c] = start_q[c];
        down[c] = (c >= PAIR_LO) & compm & dir_q[c];
      end
      // pwm and paired modes force both registers to compare
      cmpa[c] = ~ctrl_q[c][CAP_A_BIT] | mode_q[c] | ((c >= PAIR_LO) & pairm);
      cmpb[c] = ~ctrl_q[c][CAP_B_BIT] | mode_q[c] | ((c >= PAIR_LO) & pairm);
      // match fires on the tick that moves the counter off the value
      seta[c] = cmpa[c] ? (tick[c] & (cnt_q[c] == gra_q[c]))
                        : (ctrl_q[c][BOTH_BIT] ? capture_compare_pin_a_i[c] ^ pa_q[c]
                                               : capture_compare_pin_a_i[c] & ~pa_q[c]);
      setb[c] = cmpb[c] ? (tick[c] & (cnt_q[c] == grb_q[c]))
                        : (ctrl_q[c][BOTH_BIT] ? capture_compare_pin_b_i[c] ^ pb_q[c]
                                               : capture_compare_pin_b_i[c] & ~pb_q[c]);
      if (c == NCH - 1 && rsyncm) begin
        seta[c] = 1'b0;
        setb[c] = 1'b0;
      end
      wrap[c] = tick[c] & (down[c] ? cnt_q[c] == CNT_ZERO : cnt_q[c] == CNT_MAX);
      clro[c] = (ctrl_q[c][1:0] == CLR_A & seta[c]) | (ctrl_q[c][1:0] == CLR_B & setb[c]);
      wcnt[c] = bus_wr_i & (hit(adr(c, OFS_CNT)) | hit(adr(c, OFS_CNT | 4'h1)));
      any_w   = any_w | (wcnt[c] & sync_q[c]);
      any_c   = any_c | (clro[c] & sync_q[c]);
    end
    for (int c = 0; c < NCH; c++) begin
      load[c] = wcnt[c] | (sync_q[c] & any_w);
      clr[c]  = clro[c] | (sync_q[c] & any_c & ctrl_q[c][1:0] == CLR_SYNC);
      fclr[c] = (bus_wr_i & hit(adr(c, OFS_FLAGS))) ? arm_q[c] & ~3'(bdat(adr(c, OFS_FLAGS)))
                                                    : 3'h0;
      if (c < DMA_NCH && dma_ack_a_i[c]) fclr[c][EVA_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < NCH; c++) cnt_q[c] <= CNT_ZERO;
      dir_q <= '0;
    end else if (ce_i) begin
      for (int c = 0; c < NCH; c++) begin
        if (load[c]) cnt_q[c] <= wval;
        else if (clr[c]) cnt_q[c] <= CNT_ZERO;
        else if (tick[c] & down[c]) cnt_q[c] <= cnt_q[c] - 16'h0001;
        else if (tick[c]) cnt_q[c] <= cnt_q[c] + 16'h0001;
        // complementary turn points: top of channel 3 period, and underflow
        if (!compm) dir_q[c] <= 1'b0;
        else if (tick[c] & ~dir_q[c] & cnt_q[c] == gra_q[PAIR_LO]) dir_q[c] <= 1'b1;
        else if (wrap[c] & dir_q[c]) dir_q[c] <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < NCH; c++) begin
        flg_q[c] <= FLAGS_RST[2:0];
        en_q[c]  <= EN_RST[2:0];
        arm_q[c] <= 3'h0;
      end
    end else if (ce_i) begin
      for (int c = 0; c < NCH; c++) begin
        if (standby_i) begin
          flg_q[c] <= FLAGS_RST[2:0];
          en_q[c]  <= EN_RST[2:0];
          arm_q[c] <= 3'h0;
        end else begin
          // set beats clear so a coincident event survives
          flg_q[c] <= (flg_q[c] & ~fclr[c]) | {wrap[c], setb[c], seta[c]};
          arm_q[c] <= (arm_q[c] | ((bus_rd_i & hit(adr(c, OFS_FLAGS))) ? flg_q[c] : 3'h0))
                      & ~fclr[c];
          if (bus_wr_i & hit(adr(c, OFS_EN))) en_q[c] <= 3'(bdat(adr(c, OFS_EN)));
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_q[c] <= 8'h00;
        gra_q[c]  <= CNT_MAX;
        grb_q[c]  <= CNT_MAX;
        bra_q[c]  <= CNT_MAX;
        brb_q[c]  <= CNT_MAX;
      end
      start_q <= '0;
      sync_q  <= '0;
      mode_q  <= 8'h00;
      func_q  <= 8'h00;
    end else if (ce_i) begin
      if (bus_wr_i) begin
        for (int c = 0; c < NCH; c++) begin
          if (hit(adr(c, OFS_CTRL))) ctrl_q[c] <= bdat(adr(c, OFS_CTRL));
          gra_q[c] <= wr16(gra_q[c], adr(c, OFS_GRA));
          grb_q[c] <= wr16(grb_q[c], adr(c, OFS_GRB));
          bra_q[c] <= wr16(bra_q[c], adr(c, OFS_BRA));
          brb_q[c] <= wr16(brb_q[c], adr(c, OFS_BRB));
        end
        if (hit(ADR_START)) start_q <= 5'(bdat(ADR_START));
        if (hit(ADR_SYNC)) sync_q <= 5'(bdat(ADR_SYNC));
        if (hit(ADR_MODE)) mode_q <= bdat(ADR_MODE);
        if (hit(ADR_FUNC)) func_q <= bdat(ADR_FUNC);
      end
      // capture beats a CPU write in the same cycle
      for (int c = 0; c < NCH; c++) begin
        if (!cmpa[c] & seta[c]) gra_q[c] <= cnt_q[c];
        if (!cmpb[c] & setb[c]) grb_q[c] <= cnt_q[c];
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pa_q    <= '0;
      pb_q    <= '0;
      qa_q    <= 1'b0;
      qb_q    <= 1'b0;
      outa_q  <= '0;
      outb_q  <= '0;
      ph_q    <= 3'h0;
      rdata_q <= 16'h0000;
    end else if (ce_i) begin
      pa_q <= capture_compare_pin_a_i;
      pb_q <= capture_compare_pin_b_i;
      qa_q <= ext_clock_in_a_i;
      qb_q <= ext_clock_in_b_i;
      for (int c = 0; c < NCH; c++) begin
        if (mode_q[c]) begin
          if (setb[c]) outa_q[c] <= 1'b0;
          else if (seta[c]) outa_q[c] <= 1'b1;
        end else begin
          if (cmpa[c] & seta[c]) outa_q[c] <= ~outa_q[c];
          if (cmpb[c] & setb[c]) outb_q[c] <= ~outb_q[c];
        end
      end
      // three phases share counter 3 as common time base
      ph_q <= {cnt_q[PAIR_LO] > grb_q[NCH-1], cnt_q[PAIR_LO] > gra_q[NCH-1],
               cnt_q[PAIR_LO] > grb_q[PAIR_LO]};
      if (bus_rd_i)
        rdata_q <= bus_word_i ? {rbyte(bus_addr_i & 7'h7E), rbyte(bus_addr_i | 7'h01)}
                              : {8'h00, rbyte(bus_addr_i)};
    end
  end

  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      wrap_irq_request_o[c]    = flg_q[c][WRAP_BIT] & en_q[c][WRAP_BIT];
      event_b_irq_request_o[c] = flg_q[c][EVB_BIT] & en_q[c][EVB_BIT];
      event_a_irq_request_o[c] = flg_q[c][EVA_BIT] & en_q[c][EVA_BIT];
      capture_compare_pin_a_oe_o[c] = cmpa[c];
      capture_compare_pin_b_oe_o[c] = cmpb[c] & ~mode_q[c];
    end
    capture_compare_pin_a_o = outa_q;
    capture_compare_pin_b_o = outb_q;
    inverted_out_pin_a_o    = 1'b0;
    inverted_out_pin_b_o    = 1'b0;
    if (pairm) begin
      capture_compare_pin_a_o[PAIR_LO]   = ph_q[0];
      capture_compare_pin_b_o[PAIR_LO]   = ~ph_q[0];
      capture_compare_pin_a_o[NCH-1]     = ph_q[1];
      inverted_out_pin_a_o               = ~ph_q[1];
      capture_compare_pin_b_o[NCH-1]     = ph_q[2];
      inverted_out_pin_b_o               = ~ph_q[2];
      capture_compare_pin_b_oe_o[PAIR_LO] = 1'b1;
      capture_compare_pin_b_oe_o[NCH-1]   = 1'b1;
    end
  end

  assign bus_rdata_o = rdata_q;

  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  flags_rsv_a: assert property (bus_rd_i && ce_i && !bus_word_i && bus_addr_i == 7'h02
    |=> bus_rdata_o[7:3] == 5'h1F) else $error("flag reserved bits not one");
  stby_en_a: assert property (standby_i && ce_i |=> en_q[1] == 3'h0 && flg_q[1] == 3'h0)
    else $error("standby left enables or flags set");
  wrap_set_a: assert property (wrap[0] && ce_i && !standby_i |=> flg_q[0][WRAP_BIT])
    else $error("wrap did not set flag");
  one_noset_a: assert property (bus_wr_i && ce_i && !bus_word_i && bus_addr_i == 7'h02
    && !flg_q[0][0] && !seta[0] |=> !flg_q[0][0]) else $error("writing one set a flag");
  evb_set_a: assert property (setb[1] && ce_i && !standby_i |=> flg_q[1][EVB_BIT])
    else $error("event B lost");
  dma_clr_a: assert property (dma_ack_a_i[0] && ce_i && !seta[0]
    |=> !flg_q[0][EVA_BIT]) else $error("dma start did not clear flag");
  irq_hold_a: assert property (wrap_irq_request_o[2] && !fclr[2][2] && !standby_i
    && !(bus_wr_i && hit(adr(2, OFS_EN))) |=> wrap_irq_request_o[2]) else $error("request dropped");
  sync_load_a: assert property (sync_q[0] && sync_q[1] && wcnt[0] && ce_i
    |=> cnt_q[0] == cnt_q[1]) else $error("grouped counters differ after load");
  up_wrap_a: assert property (wrap[0] && !down[0] && !load[0] && !clr[0] && ce_i
    |=> cnt_q[0] == CNT_ZERO ##1 ($past(load[0]) || cnt_q[0] != CNT_MAX))
    else $error("counter stalled after wrap");
  match_cnt_a: assert property (tick[3] && cmpa[3] && cnt_q[3] == gra_q[3] && ce_i
    && !standby_i |=> flg_q[3][EVA_BIT]) else $error("compare event lost on counter tick");

  wrap_irq_c: cover property (wrap_irq_request_o[0]);
  clear_seq_c: cover property (bus_rd_i && bus_addr_i == 7'h02 ##1 bus_wr_i && fclr[0] != 3'h0);
  cap_b_c: cover property (setb[1] && !cmpb[1]);
  down_wrap_c: cover property (wrap[PHASE_CH] && down[PHASE_CH]);

endmodule : timer_channel_status_irq
`default_nettype wire

// ### verif/cpu_bus_model.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_bus_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] bus_rdata_i,
  output logic      [6:0]  bus_addr_o,
  output logic             bus_rd_o,
  output logic             bus_wr_o,
  output logic             bus_word_o,
  output logic      [15:0] bus_wdata_o
);
  initial begin
    bus_addr_o  = 7'h00;
    bus_rd_o    = 1'b0;
    bus_wr_o    = 1'b0;
    bus_word_o  = 1'b0;
    bus_wdata_o = 16'h0000;
  end
  // one access per call; a word access to an 8-bit pair is one cycle
  task automatic xfer(input logic wr, input logic [6:0] a, input logic word,
                      input logic [15:0] d, output logic [15:0] q);
    @(posedge clk_i);
    #1;
    bus_addr_o  = a;
    bus_word_o  = word;
    bus_wdata_o = d;
    bus_rd_o    = ~wr;
    bus_wr_o    = wr;
    @(posedge clk_i);
    #1;
    q           = bus_rdata_i;
    bus_rd_o    = 1'b0;
    bus_wr_o    = 1'b0;
    // released lines carry junk so a stale value is never mistaken for data
    bus_addr_o  = ~a;
    bus_wdata_o = ~d;
    if ($urandom_range(1, 0) == 1) @(posedge clk_i);
  endtask : xfer
endmodule : cpu_bus_model
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import timer_pkg::*;
  logic        clk_i;
  logic        rst_n_i;
  logic        standby_i;
  logic [3:0]  dma_ack_a_i;
  logic [6:0]  bus_addr;
  logic        bus_rd;
  logic        bus_wr;
  logic        bus_word;
  logic [15:0] bus_wdata;
  logic [15:0] bus_rdata;
  logic [4:0]  wrap_irq;
  logic [4:0]  eva_irq;
  logic [4:0]  evb_irq;
  logic [15:0] q;
  logic [15:0] v;
  logic [2:0]  en;
  logic        ce;
  logic        ext_b;
  logic [4:0]  cap_b;
  logic [4:0]  pin_a;
  logic [4:0]  pin_a_oe;
  int          n_high;
  int          n_errors;
  int          n_compared;

  timer_channel_status_irq dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce), .standby_i(standby_i),
    .bus_addr_i(bus_addr), .bus_rd_i(bus_rd), .bus_wr_i(bus_wr),
    .bus_word_i(bus_word), .bus_wdata_i(bus_wdata), .bus_rdata_o(bus_rdata),
    .capture_compare_pin_a_i(5'h00), .capture_compare_pin_b_i(cap_b),
    .capture_compare_pin_a_o(pin_a), .capture_compare_pin_a_oe_o(pin_a_oe),
    .capture_compare_pin_b_o(), .capture_compare_pin_b_oe_o(),
    .inverted_out_pin_a_o(), .inverted_out_pin_b_o(),
    .ext_clock_in_a_i(1'b0), .ext_clock_in_b_i(ext_b), .dma_ack_a_i(dma_ack_a_i),
    .wrap_irq_request_o(wrap_irq), .event_a_irq_request_o(eva_irq),
    .event_b_irq_request_o(evb_irq)
  );
  cpu_bus_model cpu (
    .clk_i(clk_i), .bus_rdata_i(bus_rdata), .bus_addr_o(bus_addr), .bus_rd_o(bus_rd),
    .bus_wr_o(bus_wr), .bus_word_o(bus_word), .bus_wdata_o(bus_wdata)
  );

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [6:0] adr(input int c, input logic [3:0] o);
    return {c[2:0], o};
  endfunction : adr
  function automatic logic [15:0] exp_reg(input logic [2:0] b);
    return {8'h00, RO_MASK | {5'h00, b}};
  endfunction : exp_reg

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg
  task automatic chk_irq(input logic [4:0] got, input logic [4:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t irq got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_irq
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic w);
    cpu.xfer(1'b1, a, w, d, q);
  endtask : wr
  task automatic rd(input logic [6:0] a, input logic w);
    cpu.xfer(1'b0, a, w, 16'h0000, q);
  endtask : rd
  // counter sits on FFFF which also equals both general registers after reset
  task automatic run_wrap(input int c);
    wr(adr(c, OFS_CNT), 16'hFFFF, 1'b1);
    wr(ADR_START, 16'(1 << c), 1'b0);
    repeat (3) @(posedge clk_i);
    wr(ADR_START, 16'h0000, 1'b0);
  endtask : run_wrap
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  initial begin
    #400us;
    n_errors++;
    stop_test();
  end

  initial begin
    n_errors = 0;
    n_compared = 0;
    rst_n_i = 1'b0;
    standby_i = 1'b0;
    dma_ack_a_i = 4'h0;
    ce = 1'b1;
    ext_b = 1'b0;
    cap_b = 5'h00;
    void'($urandom(74638));
    repeat (20) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
    for (int c = 0; c < NCH; c++) begin
      rd(adr(c, OFS_FLAGS), 1'b0);
      chk_reg(q, exp_reg(3'h0));
      rd(adr(c, OFS_EN), 1'b0);
      chk_reg(q, exp_reg(3'h0));
      wr(adr(c, OFS_EN), 16'h00FF, 1'b0);
      rd(adr(c, OFS_EN), 1'b0);
      chk_reg(q, exp_reg(3'h7));
      wr(adr(c, OFS_EN), 16'h0000, 1'b0);
      wr(adr(c, OFS_FLAGS), 16'h00FF, 1'b0);
      rd(adr(c, OFS_FLAGS), 1'b0);
      chk_reg(q, exp_reg(3'h0));
    end
    $display("done reset and fixed bits");
    for (int c = 0; c < NCH; c++) begin
      en = 3'($urandom_range(7, 0));
      wr(adr(c, OFS_EN), {13'h0000, en}, 1'b0);
      run_wrap(c);
      wr(adr(c, OFS_FLAGS), 16'h0000, 1'b0);
      rd(adr(c, OFS_FLAGS), 1'b0);
      chk_reg(q, exp_reg(3'h7));
      chk_irq({2'b00, wrap_irq[c], evb_irq[c], eva_irq[c]}, {2'b00, en});
      wr(adr(c, OFS_FLAGS), 16'h00FE, 1'b0);
      rd(adr(c, OFS_FLAGS), 1'b0);
      chk_reg(q, exp_reg(3'h6));
      wr(adr(c, OFS_FLAGS), 16'h0000, 1'b0);
      rd(adr(c, OFS_FLAGS), 1'b0);
      chk_reg(q, exp_reg(3'h0));
      chk_irq({2'b00, wrap_irq[c], evb_irq[c], eva_irq[c]}, 5'h00);
    end
    $display("done wrap, compare and clear");
    for (int c = 0; c < NCH; c++) begin
      wr(adr(c, OFS_EN), 16'h0007, 1'b0);
      run_wrap(c);
      if (c < DMA_NCH) begin
        @(posedge clk_i);
        #1 dma_ack_a_i = 4'(1 << c);
        @(posedge clk_i);
        #1 dma_ack_a_i = 4'h0;
        rd(adr(c, OFS_FLAGS), 1'b0);
        chk_reg(q, exp_reg(3'h6));
      end
    end
    chk_irq(wrap_irq, 5'h1F);
    @(posedge clk_i);
    #1 standby_i = 1'b1;
    @(posedge clk_i);
    #1 standby_i = 1'b0;
    chk_irq(wrap_irq | eva_irq | evb_irq, 5'h00);
    for (int c = 0; c < NCH; c++) begin
      rd(adr(c, OFS_FLAGS), 1'b1);
      chk_reg(q, 16'hF8F8);
    end
    rd(7'h7F, 1'b0);
    chk_reg(q, 16'h0000);
    $display("done dma clear and standby");
    for (int i = 0; i < 4; i++) begin
      int c;
      c = $urandom_range(NCH - 1, 0);
      v = 16'($urandom());
      wr(adr(c, OFS_GRA), v, 1'b1);
      rd(adr(c, OFS_GRA), 1'b0);
      chk_reg(q, {8'h00, v[15:8]});
      rd(adr(c, OFS_GRA) + 7'h01, 1'b0);
      chk_reg(q, {8'h00, v[7:0]});
      wr(adr(c, OFS_GRA) + 7'h01, 16'h005A, 1'b0);
      rd(adr(c, OFS_GRA), 1'b1);
      chk_reg(q, {v[15:8], 8'h5A});
    end
    wr(ADR_SYNC, 16'h0003, 1'b0);
    wr(adr(0, OFS_CNT), 16'h1234, 1'b1);
    rd(adr(1, OFS_CNT), 1'b1);
    chk_reg(q, 16'h1234);
    $display("done wide access and preset");
    // clock enable low: the write must not land
    @(posedge clk_i);
    #1 ce = 1'b0;
    wr(adr(0, OFS_EN), 16'h0007, 1'b0);
    @(posedge clk_i);
    #1 ce = 1'b1;
    rd(adr(0, OFS_EN), 1'b0);
    chk_reg(q, exp_reg(3'h0));
    // rising edge on pin B of channel 1 captures the preset counter
    wr(adr(1, OFS_CTRL), 16'h0020, 1'b0);
    @(posedge clk_i);
    #1 cap_b = 5'h02;
    rd(adr(1, OFS_FLAGS), 1'b0);
    chk_reg(q, exp_reg(3'h2));
    rd(adr(1, OFS_GRB), 1'b1);
    chk_reg(q, 16'h1234);
    // one backward phase step from zero underflows channel 2
    wr(ADR_MODE, 16'h0040, 1'b0);
    wr(adr(PHASE_CH, OFS_CNT), 16'h0000, 1'b1);
    wr(ADR_START, 16'h0004, 1'b0);
    @(posedge clk_i);
    #1 ext_b = 1'b1;
    repeat (2) @(posedge clk_i);
    wr(ADR_START, 16'h0000, 1'b0);
    rd(adr(PHASE_CH, OFS_CNT), 1'b1);
    chk_reg(q, 16'hFFFF);
    rd(adr(PHASE_CH, OFS_FLAGS), 1'b0);
    chk_reg(q, exp_reg(3'h4));
    // pwm on channel 0: high from match A to match B, period five counts
    wr(adr(0, OFS_GRA), 16'h0002, 1'b1);
    wr(adr(0, OFS_GRB), 16'h0004, 1'b1);
    wr(adr(0, OFS_CTRL), {14'h0000, CLR_B}, 1'b0);
    wr(adr(0, OFS_CNT), 16'h0000, 1'b1);
    wr(ADR_MODE, 16'h0001, 1'b0);
    wr(ADR_START, 16'h0001, 1'b0);
    repeat (6) @(posedge clk_i);
    n_high = 0;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk_i);
      #1;
      if (pin_a[0] === 1'b1) n_high++;
    end
    wr(ADR_START, 16'h0000, 1'b0);
    chk_reg(16'(n_high), 16'h0008);
    chk_irq(pin_a_oe, 5'h1F);
    $display("done enable, capture, phase count and pwm");
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
